// ### verilog/csf_status.sv
`timescale 1ns/1ns
`include "csf_consts.svh"
module csf_status import csf_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // instruction issue and hardware events
  input wire csf_req_t req,
  input wire csf_evt_t evt,
  // indirect pointer and direct address in
  input wire logic [7:0] fsr_ptr,
  input wire logic [6:0] dir_addr,
  // results
  output logic [7:0] result_reg,
  output logic [7:0] status_reg,
  output logic [8:0] direct_addr_reg,
  output logic [8:0] indirect_addr_reg
);
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] bop;
  logic cin;
  logic [7:0] res_next;
  logic z_upd, dc_upd, c_upd, z_n, dc_n, c_n;
  logic [7:0] st_next;

  // alu: subtract adds two's complement of the second operand
  always_comb begin
    bop = (req.op == CSF_OP_SUB) ? ~req.b : req.b;
    cin = (req.op == CSF_OP_SUB);
    sum = {1'b0, req.a} + {1'b0, bop} + {8'h00, cin};
    half = {1'b0, req.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
    res_next = req.a;
    z_upd = 1'b0;
    dc_upd = 1'b0;
    c_upd = 1'b0;
    dc_n = half[4];
    c_n = sum[8];
    case (req.op)
      CSF_OP_ADD, CSF_OP_SUB: begin
        res_next = sum[7:0];
        z_upd = 1'b1;
        dc_upd = 1'b1;
        c_upd = 1'b1;
      end
      CSF_OP_LOGIC: begin
        res_next = req.b;
        z_upd = 1'b1;
      end
      CSF_OP_PASS_Z: begin
        res_next = req.a;
        z_upd = 1'b1;
      end
      CSF_OP_RRC: begin
        res_next = {status_reg[`CSF_BIT_C_POS], req.a[7:1]};
        c_n = req.a[0];
        c_upd = 1'b1;
      end
      CSF_OP_RLC: begin
        res_next = {req.a[6:0], status_reg[`CSF_BIT_C_POS]};
        c_n = req.a[7];
        c_upd = 1'b1;
      end
      CSF_OP_CLEAR: begin
        res_next = 8'h00;
        z_upd = 1'b1;
      end
      CSF_OP_PASS: res_next = req.a;
      default: res_next = req.a;
    endcase
    z_n = (res_next == 8'h00);
  end

  // merge instruction write, alu flags and hardware events
  always_comb begin
    st_next = status_reg;
    if (req.valid && req.wr_status) begin
      // expiry and power-down are never written by instructions
      st_next[7:5] = res_next[7:5];
      st_next[2] = res_next[2];
      // clear leaves half carry and carry as they were
      if (req.op != CSF_OP_CLEAR) begin
        st_next[1:0] = res_next[1:0];
      end
    end
    if (req.valid) begin
      // flag results win over the written value
      if (z_upd) st_next[`CSF_BIT_Z_POS] = z_n;
      if (dc_upd) st_next[`CSF_BIT_HALF_POS] = dc_n;
      if (c_upd) st_next[`CSF_BIT_C_POS] = c_n;
    end
    if (evt.timeout) st_next[`CSF_BIT_EXPIRY_POS] = 1'b0;
    if (evt.sleep) begin
      st_next[`CSF_BIT_EXPIRY_POS] = 1'b1;
      st_next[`CSF_BIT_PWRDN_POS] = 1'b0;
    end
    if (evt.refresh) begin
      st_next[`CSF_BIT_EXPIRY_POS] = 1'b1;
      st_next[`CSF_BIT_PWRDN_POS] = 1'b1;
    end
  end

  // status register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_reg <= `CSF_RESET_VALUE;
    end else begin
      status_reg <= st_next;
    end
  end

  // datapath result
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_reg <= 8'h00;
    end else if (req.valid) begin
      result_reg <= res_next;
    end
  end

  // bank-extended addresses from the new status value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      direct_addr_reg <= 9'h000;
      indirect_addr_reg <= 9'h000;
    end else begin
      direct_addr_reg <= {st_next[`CSF_BIT_DIR_BANK_HI:`CSF_BIT_DIR_BANK_LO], dir_addr};
      indirect_addr_reg <= {st_next[`CSF_BIT_IND_BANK_POS], fsr_ptr};
    end
  end
endmodule

// ### verilog/csf_consts.svh
// Summary of operation
// - flag-updating ops override written arithmetic flags
// - expiry and power-down flags ignore writes
// - clear with status write clears bank bits, sets zero flag
// - indirect bank bit selects banks 2-3
// - direct bank bits select bank 0-3
// - expiry flag set refresh/sleep, cleared timeout
// - power-down flag set refresh, cleared sleep
// - zero flag follows zero result
// - half carry from bit 3 carry-out
// - carry from most significant bit carry-out
// - subtract adds two's complement; carry means no-borrow
// - rotates load carry with shifted-out bit
// - reset: bank bits zero, expiry/power-down one
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH
`define CSF_BIT_IND_BANK_POS 7
`define CSF_BIT_DIR_BANK_HI 6
`define CSF_BIT_DIR_BANK_LO 5
`define CSF_BIT_EXPIRY_POS 4
`define CSF_BIT_PWRDN_POS 3
`define CSF_BIT_Z_POS 2
`define CSF_BIT_HALF_POS 1
`define CSF_BIT_C_POS 0
`define CSF_RESET_VALUE 8'h18
`define CSF_RESET_MASK 8'hF8
`endif

// ### verilog/csf_pkg.sv
package csf_pkg;
  // alu operations presented by the execution datapath
  typedef enum logic [3:0] {
    CSF_OP_NONE = 4'h0,
    CSF_OP_ADD = 4'h1,
    CSF_OP_SUB = 4'h2,
    CSF_OP_LOGIC = 4'h3,
    CSF_OP_RRC = 4'h4,
    CSF_OP_RLC = 4'h5,
    CSF_OP_CLEAR = 4'h6,
    CSF_OP_PASS = 4'h7,
    CSF_OP_PASS_Z = 4'h8
  } csf_op_t;
  // one instruction issue
  typedef struct packed {
    logic valid;
    csf_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic wr_status;
  } csf_req_t;
  // hardware events for the reset-cause flags
  typedef struct packed {
    logic refresh;
    logic sleep;
    logic timeout;
  } csf_evt_t;
endpackage

// ### dv/csf_status_checker.sv
`timescale 1ns/1ns
module csf_status_checker import csf_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched signals
  input wire csf_req_t req,
  input wire csf_evt_t evt,
  input wire logic [6:0] dir_addr,
  input wire logic [7:0] status_reg,
  input wire logic [8:0] direct_addr_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // reset-cause flags follow events only
  sleep_flags_a: assert property (evt == 3'b010 |=> status_reg[4:3] == 2'h2) else $error("sleep");
  refresh_flags_a: assert property (evt.refresh |=> status_reg[4:3] == 2'h3) else $error("refresh");
  timeout_flag_a: assert property (evt == 3'b001 |=> !status_reg[4]) else $error("timeout");
  hold_flags_a: assert property (evt == 3'b000 |=> $stable(status_reg[4:3])) else $error("hold");
  // clear sets zero; bank bits feed the address
  clear_zero_a: assert property (req.valid && req.op == CSF_OP_CLEAR |=> status_reg[2]) else $error("clr");
  bank_addr_a: assert property (1 |=> direct_addr_reg == {status_reg[6:5], $past(dir_addr)}) else $error("bank");
endmodule

// ### dv/csf_exec_model.sv
`timescale 1ns/1ns
module csf_exec_model import csf_pkg::*; (
  input wire logic ref_clk,
  output csf_req_t req
);
  initial req = '0;
  // one instruction; released operands turn inverse so stale data cannot pass
  task automatic issue(input csf_op_t op, input logic [7:0] a, input logic [7:0] b, input logic ws);
    @(negedge ref_clk);
    req <= '{1'b1, op, a, b, ws};
    @(negedge ref_clk);
    req <= '{1'b0, CSF_OP_NONE, ~a, ~b, 1'b0};
  endtask
endmodule

// ### dv/csf_status_tb.sv
`timescale 1ns/1ns
module csf_status_tb import csf_pkg::*;;
  logic ref_clk = 0, rst = 1;
  csf_req_t req;
  csf_evt_t evt = '0;
  logic [7:0] fsr_ptr = 8'h5A;
  logic [6:0] dir_addr = 7'h33;
  logic [7:0] result_reg, status_reg;
  logic [8:0] direct_addr_reg, indirect_addr_reg;
  int errors = 0, total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  csf_exec_model m (.ref_clk, .req);
  csf_status dut (.ref_clk, .rst, .req, .evt, .fsr_ptr, .dir_addr,
    .result_reg, .status_reg, .direct_addr_reg, .indirect_addr_reg);
  // compare and count
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle hardware event
  task automatic pulse(input csf_evt_t e);
    @(negedge ref_clk);
    evt = e;
    @(negedge ref_clk);
    evt = '0;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // instruction and event sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 0;
    chk(status_reg[7:3], 9'h03);
    m.issue(CSF_OP_ADD, 8'hFF, 8'h01, 0);
    chk({result_reg, status_reg[2]}, 9'h01);
    chk(status_reg[1:0], 9'h3);
    m.issue(CSF_OP_SUB, 8'h01, 8'h02, 0);
    chk(status_reg[2:0], 9'h0);
    m.issue(CSF_OP_PASS, 8'hFF, 8'h00, 1);
    chk(status_reg, 9'hFF);
    chk(indirect_addr_reg, 9'h15A);
    chk(direct_addr_reg, 9'h1B3);
    fsr_ptr = 8'hA5;
    dir_addr = 7'h4C;
    m.issue(CSF_OP_CLEAR, 8'h00, 8'h00, 1);
    chk(status_reg, 9'h1F);
    chk(direct_addr_reg, 9'h04C);
    chk(indirect_addr_reg, 9'h0A5);
    m.issue(CSF_OP_ADD, 8'h01, 8'h01, 1);
    chk(status_reg, 9'h18);
    m.issue(CSF_OP_RLC, 8'h80, 8'h00, 0);
    chk(status_reg[0], 9'h1);
    m.issue(CSF_OP_RRC, 8'h02, 8'h00, 0);
    chk(status_reg[0], 9'h0);
    pulse(3'b010);
    chk(status_reg[4:3], 9'h2);
    pulse(3'b001);
    chk(status_reg[4:3], 9'h0);
    pulse(3'b100);
    chk(status_reg[4:3], 9'h3);
    give_verdict();
  end
endmodule
bind csf_status csf_status_checker chk_i (.ref_clk, .rst, .req, .evt, .dir_addr, .status_reg, .direct_addr_reg);
